// File: design/dtmfs_pkg.sv
/*
 * Shared constants of the tone dialer: clock rates, tone divisors,
 * sample codes, mute hold time and the register map.
 * Assumes a single 10 MHz system clock feeds every block.
 */
package dtmfs_pkg;

   // -----------------------------------------------------------------
   // Clocking
   // -----------------------------------------------------------------
   localparam int CLK_HZ  = 10_000_000;
   localparam int REF_HZ  = 500_000;
   localparam int REF_DIV = CLK_HZ / REF_HZ;   // System cycles per reference tick

   // -----------------------------------------------------------------
   // Tone synthesis
   // -----------------------------------------------------------------
   localparam int DIV_W  = 10;
   localparam int SAMP_W = 8;
   localparam int STEPS  = 16;                 // Samples per tone period
   // Reference ticks per tone period; 500 kHz divided by these gives the tones
   localparam logic [DIV_W-1:0] ROW1_DIV = 10'h2ce;   // 696.4 Hz
   localparam logic [DIV_W-1:0] ROW2_DIV = 10'h28a;   // 769.2 Hz
   localparam logic [DIV_W-1:0] ROW3_DIV = 10'h24a;   // 853.2 Hz
   localparam logic [DIV_W-1:0] ROW4_DIV = 10'h214;   // 939.8 Hz
   localparam logic [DIV_W-1:0] COL1_DIV = 10'h19e;   // 1207.7 Hz
   localparam logic [DIV_W-1:0] COL2_DIV = 10'h176;   // 1336.9 Hz
   localparam logic [DIV_W-1:0] COL3_DIV = 10'h152;   // 1479.3 Hz
   localparam logic [DIV_W-1:0] COL4_DIV = 10'h132;   // 1634.0 Hz
   localparam logic [SAMP_W-1:0] SAMP_MID = 8'h80;

   // -----------------------------------------------------------------
   // Receiver mute hold
   // -----------------------------------------------------------------
   localparam int MUTE_HOLD_MS  = 20;
   localparam int MUTE_HOLD_CYC = MUTE_HOLD_MS * (CLK_HZ / 1000);

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS      = 12'h000;
   localparam logic [11:0] STATUS_OFS    = 12'h004;
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_MM_BIT   = 1;
   localparam logic [1:0]  CTRL_RST      = 2'h1;
   localparam int          ST_ROW_BIT    = 0;
   localparam int          ST_COL_BIT    = 1;
   localparam int          ST_RIDX_LSB   = 2;
   localparam int          ST_CIDX_LSB   = 4;
   localparam int          ST_RXM_BIT    = 6;
   localparam int          ST_MICM_BIT   = 7;
   localparam int          ST_LOAD_BIT   = 8;

endpackage

// File: design/dtmfs_tone_gen.sv
/*
 * One tone generator: fractional divider plus 16-step sine table.
 * Assumes ref_tick_i is a one-cycle pulse at the reference rate and
 * div_i is steady while en_i is high.
 */
`timescale 1ns/1ps
module dtmfs_tone_gen #(
   parameter int DIV_W  = 10,
   parameter int SAMP_W = 8
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ref_tick_i,
   input  wire logic              en_i,
   input  wire logic [DIV_W-1:0]  div_i,
   output logic      [SAMP_W-1:0] sample_o
);

   localparam logic [DIV_W:0] STEP_INC = (DIV_W+1)'(dtmfs_pkg::STEPS);

   logic [DIV_W-1:0] acc_r;
   logic [3:0]       step_r;
   logic [DIV_W:0]   acc_sum;
   logic             wrap;

   // Sine codes around mid-scale, one per step
   function automatic logic [7:0] sine_code(input logic [3:0] k);
      case (k)
         4'h0, 4'h8: sine_code = 8'h80;
         4'h1, 4'h7: sine_code = 8'hb1;
         4'h2, 4'h6: sine_code = 8'hda;
         4'h3, 4'h5: sine_code = 8'hf5;
         4'h4:       sine_code = 8'hff;
         4'h9, 4'hf: sine_code = 8'h4f;
         4'ha, 4'he: sine_code = 8'h26;
         4'hb, 4'hd: sine_code = 8'h0b;
         default:    sine_code = 8'h01;
      endcase
   endfunction

   // Adding 16 per tick and wrapping at div gives exactly 16 steps per
   // div ticks, so the step length alternates between floor and ceiling
   assign acc_sum = {1'b0, acc_r} + STEP_INC;
   assign wrap    = (acc_sum >= {1'b0, div_i});

   // Phase accumulator and step counter; idle resets the phase
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         acc_r  <= '0;
         step_r <= '0;
      end else if (ref_tick_i) begin
         if (wrap) begin
            acc_r  <= DIV_W'(acc_sum - {1'b0, div_i});
            step_r <= step_r + 4'h1;
         end else begin
            acc_r  <= DIV_W'(acc_sum);
         end
      end
   end

   // Sample register feeding the D/A converter
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         sample_o <= SAMP_W'(dtmfs_pkg::SAMP_MID);
      end else begin
         sample_o <= SAMP_W'(sine_code(step_r));
      end
   end

   property p_step_adv;
      @(posedge clk_i) disable iff (rst_i)
      (en_i && ref_tick_i && wrap) |=> (step_r == 4'(($past(step_r) + 4'h1)));
   endproperty
   a_step_adv: assert property (p_step_adv) else $error("Step did not advance on wrap");

   property p_acc_bound;
      @(posedge clk_i) disable iff (rst_i)
      (en_i && $stable(div_i)) |=> (acc_r < $past(div_i));
   endproperty
   a_acc_bound: assert property (p_acc_bound) else $error("Phase accumulator beyond divisor");

endmodule

// File: design/dtmfs_top.sv
/*
 * Tone dialer digital core: keypad decode, row and column tone
 * generators, dummy load and mute controls, APB register slave.
 * Assumes keypad and mute pins are asynchronous to SYS_CLK_I and an
 * APB master on the system clock.
 */
// Decided for this implementation: the register offsets and the APB slave port.
// Functional notes
// - One row with one column enables both the row and the column tone.
// - Two keys on one row or one column give only the uniquely known tone.
// - Tone periods come from fractional counters within 0.16 percent of nominal.
// - Each generator steps through 16 sine codes per tone period.
// - Rows one to four give 696.4, 769.2, 853.2 and 939.8 Hz from 500 kHz.
// - Columns one to four give 1207.7, 1336.9, 1479.3 and about 1634 Hz.
// - The dummy load enable drops while dialing and returns when it ends.
// - The receiver is muted while dialing and on keypad changes or off-hook.
// - The microphone is muted while dialing or when its mute input is high.
// - The receiver stays muted about 20 ms after off-hook or key release.
`timescale 1ns/1ps
module dtmfs_top #(
   parameter int MUTE_HOLD_CYC = dtmfs_pkg::MUTE_HOLD_CYC
) (
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_I,
   input  wire logic [3:0]  KEYPAD_ROW_N_I,
   input  wire logic [3:0]  KEYPAD_COLUMN_I,
   input  wire logic        MICROPHONE_MUTE_IN_I,
   input  wire logic        HOOK_OFF_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   output logic      [7:0]  ROW_DAC_O,
   output logic      [7:0]  COL_DAC_O,
   output logic             DIAL_ACTIVE_O,
   output logic             DUMMY_LOAD_EN_O,
   output logic             RECEIVER_MUTE_O,
   output logic             MIC_MUTE_O
);

   localparam int TMR_W = $clog2(MUTE_HOLD_CYC + 1);
   localparam logic [TMR_W-1:0] HOLD_LOAD = TMR_W'(MUTE_HOLD_CYC);
   localparam logic [4:0] REF_LAST = 5'(dtmfs_pkg::REF_DIV - 1);

   logic [9:0]       sync1_r, sync2_r;
   logic [3:0]       rows, cols, rows_prev_r, cols_prev_r;
   logic             hook_prev_r, mm_sync;
   logic             row_go, col_go, dial_go, key_change, hook_rise;
   logic [1:0]       row_idx, col_idx;
   logic [9:0]       row_div, col_div;
   logic [4:0]       ref_cnt_r;
   logic             ref_tick;
   logic [TMR_W-1:0] hold_r;
   logic [1:0]       ctrl_r;
   logic             access, hit_ctrl, hit_status;
   logic [31:0]      status;

   // -----------------------------------------------------------------
   // Pin synchronisers and keypad decode
   // -----------------------------------------------------------------
   function automatic logic one_hot(input logic [3:0] v);
      one_hot = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
   endfunction

   function automatic logic [1:0] hot_index(input logic [3:0] v);
      hot_index = v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
   endfunction

   // Two flops on every pin; the first is read only by the second
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         sync1_r <= 10'h00f;
         sync2_r <= 10'h00f;
      end else begin
         sync1_r <= {HOOK_OFF_I, MICROPHONE_MUTE_IN_I, KEYPAD_COLUMN_I, KEYPAD_ROW_N_I};
         sync2_r <= sync1_r;
      end
   end

   assign rows    = ~sync2_r[3:0];
   assign cols    = sync2_r[7:4];
   assign mm_sync = sync2_r[8];
   // A tone plays when its line is the only one and the other side is pressed
   assign row_go  = ctrl_r[dtmfs_pkg::CTRL_EN_BIT] && one_hot(rows) && (cols != 4'h0);
   assign col_go  = ctrl_r[dtmfs_pkg::CTRL_EN_BIT] && one_hot(cols) && (rows != 4'h0);
   assign dial_go = row_go || col_go;
   assign row_idx = hot_index(rows);
   assign col_idx = hot_index(cols);

   // Divisor selection for the two generators
   always_comb begin
      case (row_idx)
         2'h0:    row_div = dtmfs_pkg::ROW1_DIV;
         2'h1:    row_div = dtmfs_pkg::ROW2_DIV;
         2'h2:    row_div = dtmfs_pkg::ROW3_DIV;
         default: row_div = dtmfs_pkg::ROW4_DIV;
      endcase
      case (col_idx)
         2'h0:    col_div = dtmfs_pkg::COL1_DIV;
         2'h1:    col_div = dtmfs_pkg::COL2_DIV;
         2'h2:    col_div = dtmfs_pkg::COL3_DIV;
         default: col_div = dtmfs_pkg::COL4_DIV;
      endcase
   end

   // -----------------------------------------------------------------
   // Reference tick and tone generators
   // -----------------------------------------------------------------
   // 500 kHz tick stands in for the resonator so divisors match the table
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I || ref_cnt_r == REF_LAST) begin
         ref_cnt_r <= 5'h00;
      end else begin
         ref_cnt_r <= ref_cnt_r + 5'h01;
      end
   end
   assign ref_tick = (ref_cnt_r == REF_LAST);

   dtmfs_tone_gen #(.DIV_W(dtmfs_pkg::DIV_W), .SAMP_W(dtmfs_pkg::SAMP_W)) u_row_gen (
      .clk_i      (SYS_CLK_I),
      .rst_i      (RST_I),
      .ref_tick_i (ref_tick),
      .en_i       (row_go),
      .div_i      (row_div),
      .sample_o   (ROW_DAC_O)
   );

   dtmfs_tone_gen #(.DIV_W(dtmfs_pkg::DIV_W), .SAMP_W(dtmfs_pkg::SAMP_W)) u_col_gen (
      .clk_i      (SYS_CLK_I),
      .rst_i      (RST_I),
      .ref_tick_i (ref_tick),
      .en_i       (col_go),
      .div_i      (col_div),
      .sample_o   (COL_DAC_O)
   );

   // -----------------------------------------------------------------
   // Line and mute controls
   // -----------------------------------------------------------------
   assign key_change = (rows != rows_prev_r) || (cols != cols_prev_r);
   assign hook_rise  = sync2_r[9] && !hook_prev_r;

   // Previous key and hook levels for transition detection
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         rows_prev_r <= 4'h0;
         cols_prev_r <= 4'h0;
         hook_prev_r <= 1'b0;
      end else begin
         rows_prev_r <= rows;
         cols_prev_r <= cols;
         hook_prev_r <= sync2_r[9];
      end
   end

   // Every key transition and off-hook restarts the hold, so bouncing contacts stay muted
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         hold_r <= '0;
      end else if (key_change || hook_rise) begin
         hold_r <= HOLD_LOAD;
      end else if (hold_r != '0) begin
         hold_r <= hold_r - TMR_W'(1);
      end
   end

   // Registered line controls
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         DIAL_ACTIVE_O   <= 1'b0;
         DUMMY_LOAD_EN_O <= 1'b1;
         RECEIVER_MUTE_O <= 1'b0;
         MIC_MUTE_O      <= 1'b0;
      end else begin
         DIAL_ACTIVE_O   <= dial_go;
         DUMMY_LOAD_EN_O <= !dial_go;
         RECEIVER_MUTE_O <= dial_go || key_change || hook_rise || hold_r != '0;
         MIC_MUTE_O      <= dial_go || mm_sync || ctrl_r[dtmfs_pkg::CTRL_MM_BIT];
      end
   end

   // -----------------------------------------------------------------
   // APB register slave, zero wait states
   // -----------------------------------------------------------------
   assign access     = PSEL_I && PENABLE_I;
   assign hit_ctrl   = (PADDR_I == dtmfs_pkg::CTRL_OFS);
   assign hit_status = (PADDR_I == dtmfs_pkg::STATUS_OFS);
   assign PREADY_O   = 1'b1;
   assign PSLVERR_O  = access && !hit_ctrl && !hit_status;

   always_comb begin
      status = 32'h0000_0000;
      status[dtmfs_pkg::ST_ROW_BIT]                   = row_go;
      status[dtmfs_pkg::ST_COL_BIT]                   = col_go;
      status[dtmfs_pkg::ST_RIDX_LSB +: 2]             = row_idx;
      status[dtmfs_pkg::ST_CIDX_LSB +: 2]             = col_idx;
      status[dtmfs_pkg::ST_RXM_BIT]                   = RECEIVER_MUTE_O;
      status[dtmfs_pkg::ST_MICM_BIT]                  = MIC_MUTE_O;
      status[dtmfs_pkg::ST_LOAD_BIT]                  = DUMMY_LOAD_EN_O;
   end

   // Control register written in the access phase
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         ctrl_r <= dtmfs_pkg::CTRL_RST;
      end else if (access && PWRITE_I && hit_ctrl) begin
         ctrl_r <= PWDATA_I[1:0];
      end
   end

   // Read data captured in the setup phase so it is a flop in access
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         PRDATA_O <= 32'h0000_0000;
      end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
         PRDATA_O <= hit_ctrl ? {30'h0000_0000, ctrl_r} : hit_status ? status : 32'h0000_0000;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   property p_both_tones;
      (ctrl_r[0] && one_hot(rows) && one_hot(cols)) |-> (row_go && col_go) ##1 DIAL_ACTIVE_O;
   endproperty
   a_both_tones: assert property (p_both_tones) else $error("Key pair did not start both tones");

   property p_single_tone;
      (one_hot(rows) && !one_hot(cols) && cols != 4'h0) |-> !col_go ##1 (COL_DAC_O == 8'h80);
   endproperty
   a_single_tone: assert property (p_single_tone) else $error("Column tone with two columns");

   property p_row_freq;
      (row_go && row_idx == 2'h0) |-> (row_div == 10'h2ce);
   endproperty
   a_row_freq: assert property (p_row_freq) else $error("Row one divisor wrong");

   property p_col_freq;
      (col_go && col_idx == 2'h3) |-> (col_div == 10'h132);
   endproperty
   a_col_freq: assert property (p_col_freq) else $error("Column four divisor wrong");

   property p_dummy_load;
      dial_go |=> !DUMMY_LOAD_EN_O ##0 RECEIVER_MUTE_O;
   endproperty
   a_dummy_load: assert property (p_dummy_load) else $error("Load or mute wrong while dialing");

   property p_rx_mute;
      (key_change || hook_rise) |=> RECEIVER_MUTE_O [*3];
   endproperty
   a_rx_mute: assert property (p_rx_mute) else $error("Receiver not muted on transition");

   property p_mic_mute;
      (mm_sync || dial_go) |=> MIC_MUTE_O;
   endproperty
   a_mic_mute: assert property (p_mic_mute) else $error("Microphone not muted");

   property p_hold;
      (key_change || hook_rise) |=> (hold_r == HOLD_LOAD);
   endproperty
   a_hold: assert property (p_hold) else $error("Mute hold not reloaded");

   property p_idle_mid;
      (!row_go && !col_go) |=> (ROW_DAC_O == 8'h80 && COL_DAC_O == 8'h80);
   endproperty
   a_idle_mid: assert property (p_idle_mid) else $error("Idle outputs not mid-scale");

endmodule

// File: dv/dtmfs_keypad_model.sv
/*
 * Keypad partner: turns the keys the bench presses into pin levels.
 * Assumes the bench changes its key masks just after a clock edge.
 */
`timescale 1ns/1ps
module dtmfs_keypad_model (
   input  wire logic [3:0] key_row_i,
   input  wire logic [3:0] key_col_i,
   output logic      [3:0] row_n_o,
   output logic      [3:0] col_o
);
   // Pressed rows pull low and pressed columns pull high; a released line
   // rests at its pull level, so no stale value lingers on it
   assign row_n_o = ~key_row_i;
   assign col_o   = key_col_i;
endmodule

// File: dv/test_dtmf_tone_synthesizer.sv
/*
 * Self-checking bench of the tone dialer core: decode, tones, mutes, APB.
 * Assumes the keypad model as partner and a shortened mute hold time.
 */
`timescale 1ns/1ps
module test_dtmf_tone_synthesizer;
   localparam int         HOLD = 50;
   localparam logic [7:0] SINE [16] = '{8'h80, 8'hb1, 8'hda, 8'hf5, 8'hff, 8'hf5, 8'hda,
      8'hb1, 8'h80, 8'h4f, 8'h26, 8'h0b, 8'h01, 8'h0b, 8'h26, 8'h4f};
   // Tones in tenths of a hertz: rows one to four, then columns
   localparam int         F10 [8] = '{6964, 7692, 8532, 9398, 12077, 13369, 14793, 16340};
   // Key row, key column, then expected dial, column tone, row tone
   localparam logic [10:0] CASES [6] = '{{4'h1, 4'h1, 3'h7}, {4'h1, 4'h3, 3'h5},
      {4'h3, 4'h1, 3'h6}, {4'h3, 4'h3, 3'h0}, {4'h8, 4'h0, 3'h0}, {4'h0, 4'h8, 3'h0}};

   logic        clk, rst, psel, penable, pwrite, hook, mic_in, er;
   logic        pready, pslverr, dial, load_en, rx_mute, mic_mute;
   logic [3:0]  key_row, key_col, row_n, col;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  row_dac, col_dac;
   int          mismatches = 0;
   int          samples_checked = 0;

   dtmfs_keypad_model i_keys (.key_row_i(key_row), .key_col_i(key_col),
      .row_n_o(row_n), .col_o(col));

   dtmfs_top #(.MUTE_HOLD_CYC(HOLD)) i_dut (.SYS_CLK_I(clk), .RST_I(rst),
      .KEYPAD_ROW_N_I(row_n), .KEYPAD_COLUMN_I(col), .MICROPHONE_MUTE_IN_I(mic_in),
      .HOOK_OFF_I(hook), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .ROW_DAC_O(row_dac), .COL_DAC_O(col_dac), .DIAL_ACTIVE_O(dial),
      .DUMMY_LOAD_EN_O(load_en), .RECEIVER_MUTE_O(rx_mute), .MIC_MUTE_O(mic_mute));

   // 10 MHz system clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // One APB transfer; the request holds until pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Waits as long as the slave stalls; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task keys(input logic [3:0] r, input logic [3:0] c);
      @(posedge clk);
      key_row <= r;
      key_col <= c;
   endtask

   // Follows one generator through a full period: every step code, then
   // the cycle count from step one to step one again
   task automatic tone(input bit use_col, input int f10);
      int         lim, n, k;
      logic [7:0] prev, cur;
      lim = 100_000_000 / f10;
      n = 0;
      cur = 8'h80;
      while (cur === 8'h80 && n < 2000) begin
         @(posedge clk);
         cur = use_col ? col_dac : row_dac;
         n++;
      end
      chk(cur, SINE[1], "first step");
      k = 2;
      n = 0;
      while (k < 18 && n < 2 * lim) begin
         prev = cur;
         @(posedge clk);
         cur = use_col ? col_dac : row_dac;
         n++;
         if (cur !== prev) begin
            chk(cur, SINE[k % 16], "step code");
            k++;
         end
      end
      chk(n * 10000 > lim * 9984 && n * 10000 < lim * 10016, 1, "period");
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Stimulus
   // -----------------------------------------------------------------
   initial begin
      {rst, psel, penable, pwrite, hook, mic_in} = 6'h20;
      {key_row, key_col, paddr, pwdata} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({row_dac, col_dac}, 16'h8080, "idle dacs");
      chk(load_en, 1'b1, "idle load");
      chk({dial, rx_mute, mic_mute}, 3'h0, "idle mutes");
      apb(1'b0, dtmfs_pkg::CTRL_OFS, 32'h0);
      chk(rd, {30'h0, dtmfs_pkg::CTRL_RST}, "ctrl reset");
      apb(1'b0, 12'h008, 32'h0);
      chk(er, 1'b1, "unmapped error");
      chk(rd, 32'h0, "unmapped read");
      apb(1'b1, dtmfs_pkg::STATUS_OFS, 32'hffff_ffff);
      apb(1'b0, dtmfs_pkg::STATUS_OFS, 32'h0);
      chk(rd, 32'h100, "status read only");
      $display("test registers done");
      // Decode table: each case pressed, checked, released and let settle
      for (int i = 0; i < 6; i++) begin
         keys(CASES[i][10:7], CASES[i][6:3]);
         repeat (6) @(posedge clk);
         chk(dial, CASES[i][2], "dial");
         chk(load_en, !CASES[i][2], "load");
         chk(mic_mute, CASES[i][2], "mic mute");
         chk(rx_mute, 1'b1, "rx mute on change");
         apb(1'b0, dtmfs_pkg::STATUS_OFS, 32'h0);
         chk(rd[1:0], CASES[i][1:0], "tone select");
         if (!CASES[i][0]) chk(row_dac, 8'h80, "row mid");
         if (!CASES[i][1]) chk(col_dac, 8'h80, "col mid");
         keys(4'h0, 4'h0);
         repeat (HOLD + 20) @(posedge clk);
      end
      $display("test decode done");
      // Long press outlasts the hold time, then release starts it afresh
      keys(4'h2, 4'h4);
      repeat (HOLD + 20) @(posedge clk);
      chk(rx_mute, 1'b1, "rx mute while dialing");
      keys(4'h0, 4'h0);
      repeat (6) @(posedge clk);
      chk(load_en, 1'b1, "load back");
      chk({row_dac, col_dac}, 16'h8080, "dacs back");
      repeat (HOLD - 16) @(posedge clk);
      chk(rx_mute, 1'b1, "rx mute held");
      repeat (30) @(posedge clk);
      chk(rx_mute, 1'b0, "rx mute ends");
      // Off-hook and the external mic mute arrive together
      @(posedge clk);
      hook   <= 1'b1;
      mic_in <= 1'b1;
      repeat (6) @(posedge clk);
      chk(rx_mute, 1'b1, "hook mute");
      chk(mic_mute, 1'b1, "mic input");
      mic_in <= 1'b0;
      repeat (HOLD + 20) @(posedge clk);
      chk({rx_mute, mic_mute}, 2'h0, "hook mute ends");
      apb(1'b1, dtmfs_pkg::CTRL_OFS, 32'h3);
      repeat (4) @(posedge clk);
      chk(mic_mute, 1'b1, "soft mic mute");
      apb(1'b1, dtmfs_pkg::CTRL_OFS, 32'h0);
      keys(4'h1, 4'h1);
      repeat (6) @(posedge clk);
      chk(dial, 1'b0, "dial disabled");
      keys(4'h0, 4'h0);
      apb(1'b1, dtmfs_pkg::CTRL_OFS, 32'h1);
      repeat (HOLD + 20) @(posedge clk);
      $display("test mutes done");
      // Both generators measured at once to keep the run short
      for (int i = 0; i < 4; i++) begin
         keys(4'h1 << i, 4'h1 << i);
         fork
            tone(1'b0, F10[i]);
            tone(1'b1, F10[i + 4]);
         join
         keys(4'h0, 4'h0);
         repeat (HOLD + 20) @(posedge clk);
      end
      $display("test tones done");
      give_verdict();
   end

   // Watchdog: the tests need about 55000 cycles
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      $display("mismatch at %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule
